/* File: plt_defines.svh */
/*
  timing, field and reset constants for the programmable length timebase.
  assumes inclusion by the package and the timebase module only.
*/
`ifndef PLT_DEFINES_SVH
`define PLT_DEFINES_SVH

`define PLT_CLK_PERIOD_NS 100
`define PLT_WIDTH 16
`define PLT_COUNT_RESET 16'h0000
`define PLT_PERIOD_RESET 16'h0000
`define PLT_MAX_8 16'h00ff
`define PLT_MAX_10 16'h03ff
`define PLT_MAX_12 16'h0fff
`define PLT_MAX_16 16'hffff
`define PLT_ONE 16'h0001
`define PLT_DIV_LIMIT_1 3'h0
`define PLT_DIV_LIMIT_2 3'h1
`define PLT_DIV_LIMIT_4 3'h3
`define PLT_DIV_LIMIT_8 3'h7

`endif

/* File: plt_pkg.sv */
/*
  types for the programmable length timebase.
  assumes plt_defines.svh is reachable by bare name.
*/
package plt_pkg;
  `include "plt_defines.svh"

  typedef enum logic [1:0] {
    plt_mode_stop,
    plt_mode_up,
    plt_mode_cont,
    plt_mode_updown
  } plt_mode_t;

  typedef enum logic [1:0] {
    plt_len_16,
    plt_len_12,
    plt_len_10,
    plt_len_8
  } plt_len_t;

  typedef enum logic [1:0] {
    plt_src_ext,
    plt_src_aux,
    plt_src_submain,
    plt_src_alt
  } plt_src_t;

  typedef enum logic [1:0] {
    plt_div_1,
    plt_div_2,
    plt_div_4,
    plt_div_8
  } plt_div_t;

  typedef struct packed {
    plt_mode_t mode_control;
    plt_len_t length_select_field;
    plt_src_t clock_source_select;
    plt_div_t input_divider_select;
  } plt_cfg_t;

  typedef struct packed {
    logic wr;
    logic [15:0] data;
  } plt_write_t;
endpackage : plt_pkg

/* File: plt_timebase.sv */
/*
  counter core of a capture/compare timer: count register, length, mode,
  clock source and divider, period latch of channel 0, channel 0 event and
  rollover flags.
  assumes all inputs synchronous to sys_clk; clock sources arrive as levels
  whose rising edges are detected here; software pulses are one cycle wide.
*/
// What this block does
// RULE1 - count register steps up or down on each selected timer clock edge
// RULE2 - software reads and writes the count; a write takes effect at once
// RULE3 - clear bit zeroes count, divider and the counting direction
// RULE4 - length select picks 8, 10, 12 or 16 bit width and maximum
// RULE5 - narrow widths store written counts right-aligned, upper bits zero
// RULE6 - clock source select picks auxiliary, submain or two external clocks
// RULE7 - input divider passes the clock or divides by 2, 4 or 8
// RULE8 - counting only while mode nonzero and selected clock runs
// RULE9 - zero period halts up and up/down modes; nonzero restarts from zero upward
// RULE10 - mode 00 stop, 01 up, 10 continuous, 11 up/down; stop holds count
// RULE11 - up mode counts zero to period then returns to zero
// RULE12 - entering up mode above period returns count to zero at once
// RULE13 - up mode: event flag at period, rollover flag on period to zero
// RULE14 - continuous mode wraps at maximum; rollover flag on that step
// RULE15 - continuous mode period latch acts as an ordinary compare
// RULE16 - new period below count rolls to zero, else counted up to
// RULE17 - only counting sets flags; direct count writes trigger nothing
// RULE18 - up/down mode counts up to period and back down to zero
// RULE19 - compare registers are double-buffered and loadable as a group
// RULE20 - every timer output can be switched to high impedance
// RULE21 - software stops the counter before changing configuration
// RULE22 - up/down: event flag on period-1 to period; rollover on one to zero
// RULE23 - up/down with period above maximum behaves as continuous mode
// RULE24 - flags stay set until software clears them
`timescale 1ns/1ps
`include "plt_defines.svh"
module plt_timebase (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire plt_pkg::plt_cfg_t cfg,
  input wire logic counter_clear_bit,
  input wire plt_pkg::plt_write_t count_write,
  input wire plt_pkg::plt_write_t compare_write,
  input wire logic group_load,
  input wire logic aux_clock,
  input wire logic submain_clock,
  input wire logic external_timer_clock,
  input wire logic alternate_external_clock,
  input wire logic event_flag_clear,
  input wire logic rollover_flag_clear,
  input wire logic output_hiz,
  output logic [15:0] count_register,
  output logic [15:0] period_latch,
  output logic [15:0] channel0_compare_buffer,
  output logic channel_event_flag,
  output logic rollover_flag,
  output logic count_down,
  output logic timer_out,
  output logic timer_out_en
);
  import plt_pkg::*;

  function automatic logic [15:0] len_max(input plt_len_t len);
    unique case (len)
      plt_len_8: len_max = `PLT_MAX_8;
      plt_len_10: len_max = `PLT_MAX_10;
      plt_len_12: len_max = `PLT_MAX_12;
      plt_len_16: len_max = `PLT_MAX_16;
    endcase
  endfunction : len_max

  logic src_prev;
  logic [2:0] div_cnt;
  logic buffer_pending;
  logic period_was_zero;
  logic prev_mode_up;

  wire logic [15:0] max_count = len_max(cfg.length_select_field); // RULE4
  wire logic src_level = (cfg.clock_source_select == plt_src_aux) ? aux_clock :
    (cfg.clock_source_select == plt_src_submain) ? submain_clock :
    (cfg.clock_source_select == plt_src_ext) ? external_timer_clock :
    alternate_external_clock; // RULE6
  wire logic src_rise = src_level & ~src_prev;
  wire logic [2:0] div_limit = (cfg.input_divider_select == plt_div_1) ? `PLT_DIV_LIMIT_1 :
    (cfg.input_divider_select == plt_div_2) ? `PLT_DIV_LIMIT_2 :
    (cfg.input_divider_select == plt_div_4) ? `PLT_DIV_LIMIT_4 :
    `PLT_DIV_LIMIT_8; // RULE7
  wire logic div_hit = src_rise && (div_cnt >= div_limit);
  wire logic mode_up = (cfg.mode_control == plt_mode_up);
  wire logic mode_cont = (cfg.mode_control == plt_mode_cont);
  wire logic mode_ud = (cfg.mode_control == plt_mode_updown);
  wire logic period_mode = mode_up || mode_ud;
  wire logic period_zero = (period_latch == `PLT_PERIOD_RESET);
  wire logic ud_as_cont = mode_ud && (period_latch > max_count); // RULE23
  // stop mode and a zero period in period modes halt the counter
  wire logic run = (cfg.mode_control != plt_mode_stop) &&
    !(period_mode && period_zero); // RULE8 RULE9 RULE10
  wire logic tick = run && div_hit; // RULE1
  wire logic wrap_cont = mode_cont || ud_as_cont; // RULE15
  wire logic up_top = mode_up && (count_register >= period_latch); // RULE11 RULE16
  wire logic ud_top = mode_ud && !ud_as_cont && !count_down &&
    (count_register >= period_latch); // RULE18
  wire logic ud_bottom = mode_ud && !ud_as_cont && count_down &&
    (count_register == `PLT_COUNT_RESET);
  wire logic enter_up_above = mode_up && !prev_mode_up &&
    (count_register > period_latch); // RULE12
  wire logic [15:0] count_up = (count_register + `PLT_ONE) & max_count;
  wire logic [15:0] count_dn = (count_register - `PLT_ONE) & max_count;
  wire logic [15:0] next_count = (wrap_cont && count_register >= max_count) ?
    `PLT_COUNT_RESET : up_top ? `PLT_COUNT_RESET :
    (ud_top || (count_down && !ud_bottom && mode_ud && !ud_as_cont)) ? count_dn :
    count_up; // RULE14 RULE18
  wire logic next_count_down = ud_top ? 1'b1 : ud_bottom ? 1'b0 :
    (mode_ud && !ud_as_cont) ? count_down : 1'b0;
  wire logic restart = period_mode && period_was_zero && !period_zero; // RULE9
  // flags follow only a step that lands; clear, write, up entry and restart own the count
  wire logic step = tick && !counter_clear_bit && !count_write.wr && !enter_up_above &&
    !restart; // RULE17
  wire logic hit_period = (next_count == period_latch);
  wire logic set_event = (step && mode_up && hit_period && !up_top) ||
    (step && mode_ud && !count_down && !ud_as_cont && hit_period && !ud_top) ||
    (step && wrap_cont && hit_period); // RULE13 RULE15 RULE22
  wire logic set_roll = step && (
    (mode_up && up_top) ||
    (wrap_cont && count_register >= max_count) ||
    (mode_ud && !ud_as_cont && count_down && count_register == `PLT_ONE)); // RULE13 RULE14 RULE22
  // a write made while group_load is high waits in the buffer for a lone group_load pulse
  wire logic hold_for_group = compare_write.wr && group_load; // RULE19
  wire logic load_period = compare_write.wr || (group_load && buffer_pending); // RULE19

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      src_prev <= 1'b0;
      div_cnt <= 3'h0;
      prev_mode_up <= 1'b0;
    end else if (clk_en) begin
      src_prev <= src_level;
      prev_mode_up <= mode_up;
      if (counter_clear_bit || div_hit) begin
        div_cnt <= 3'h0; // RULE3
      end else if (src_rise) begin
        div_cnt <= div_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_register <= `PLT_COUNT_RESET;
      count_down <= 1'b0;
      period_was_zero <= 1'b1;
    end else if (clk_en) begin
      period_was_zero <= period_zero;
      if (counter_clear_bit) begin
        count_register <= `PLT_COUNT_RESET; // RULE3
        count_down <= 1'b0;
      end else if (count_write.wr) begin
        count_register <= count_write.data & max_count; // RULE2 RULE5
      end else if (enter_up_above) begin
        count_register <= `PLT_COUNT_RESET;
      end else if (restart) begin
        count_register <= `PLT_COUNT_RESET; // RULE9
        count_down <= 1'b0;
      end else if (tick) begin
        count_register <= next_count;
        count_down <= next_count_down;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      channel0_compare_buffer <= `PLT_PERIOD_RESET;
      period_latch <= `PLT_PERIOD_RESET;
      buffer_pending <= 1'b0;
    end else if (clk_en) begin
      if (hold_for_group) begin
        channel0_compare_buffer <= compare_write.data; // RULE19
        buffer_pending <= 1'b1;
      end else if (compare_write.wr) begin
        channel0_compare_buffer <= compare_write.data;
        period_latch <= compare_write.data;
        buffer_pending <= 1'b0;
      end else if (load_period) begin
        period_latch <= channel0_compare_buffer;
        buffer_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      channel_event_flag <= 1'b0;
      rollover_flag <= 1'b0;
      timer_out <= 1'b0;
      timer_out_en <= 1'b0;
    end else if (clk_en) begin
      // a set in the same cycle as a clear wins
      if (set_event) begin
        channel_event_flag <= 1'b1; // RULE24
      end else if (event_flag_clear) begin
        channel_event_flag <= 1'b0;
      end
      if (set_roll) begin
        rollover_flag <= 1'b1; // RULE24
      end else if (rollover_flag_clear) begin
        rollover_flag <= 1'b0;
      end
      if (set_event) begin
        timer_out <= ~timer_out;
      end
      timer_out_en <= ~output_hiz; // RULE20
    end
  end
endmodule : plt_timebase

/* File: plt_timebase_asserts.sv */
/*
  port-level checker for the programmable length timebase.
  assumes a single sys_clk domain with reset_n asynchronous active low.
*/
`timescale 1ns/1ps
module plt_timebase_asserts
  import plt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire plt_pkg::plt_cfg_t cfg,
  input wire logic counter_clear_bit,
  input wire plt_pkg::plt_write_t count_write,
  input wire logic rollover_flag_clear,
  input wire logic output_hiz,
  input wire logic [15:0] count_register,
  input wire logic rollover_flag,
  input wire logic count_down,
  input wire logic timer_out_en
);
  import plt_pkg::*;
  wire logic [15:0] max_count = (cfg.length_select_field == plt_len_8) ? 16'h00ff :
    (cfg.length_select_field == plt_len_10) ? 16'h03ff :
    (cfg.length_select_field == plt_len_12) ? 16'h0fff : 16'hffff;
  wire logic [15:0] wr_masked = count_write.data & max_count;
  wire logic is_cont = cfg.mode_control == plt_mode_cont;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_clear_count: assert property (clk_en && counter_clear_bit |=> count_register == 16'h0000 && !count_down) else $error("clear left count or direction");
  a_write_masked: assert property (clk_en && count_write.wr && !counter_clear_bit |=> count_register == $past(wr_masked)) else $error("count write not stored masked");
  a_write_noflag: assert property (clk_en && count_write.wr && !rollover_flag |=> !rollover_flag) else $error("count write set rollover");
  a_stop_hold: assert property (clk_en && cfg.mode_control == plt_mode_stop && !counter_clear_bit && !count_write.wr |=> $stable(count_register)) else $error("stop mode moved count");
  a_freeze_count: assert property (!clk_en |=> $stable(count_register)) else $error("count moved while frozen");
  a_flag_sticky: assert property (rollover_flag && !rollover_flag_clear |=> rollover_flag) else $error("rollover dropped by itself");
  a_cont_wrap: assert property (is_cont && $rose(rollover_flag) |-> count_register == 16'h0000 && $past(count_register) == max_count) else $error("bad wrap");
  a_up_wrap: assert property (cfg.mode_control == plt_mode_up && $rose(rollover_flag) |-> count_register == 16'h0000) else $error("up rollover not at zero");
  a_cont_bound: assert property (is_cont |-> count_register <= max_count) else $error("count above maximum");
  a_hiz_enable: assert property (clk_en |=> timer_out_en == !$past(output_hiz)) else $error("output enable wrong");
endmodule : plt_timebase_asserts

bind plt_timebase plt_timebase_asserts i_plt_timebase_asserts (.sys_clk(sys_clk), .reset_n(reset_n),
  .clk_en(clk_en), .cfg(cfg), .counter_clear_bit(counter_clear_bit), .count_write(count_write),
  .rollover_flag_clear(rollover_flag_clear), .output_hiz(output_hiz),
  .count_register(count_register), .rollover_flag(rollover_flag), .count_down(count_down),
  .timer_out_en(timer_out_en));

/* File: tb_top.sv */
/*
  self-checking testbench for the programmable length timebase.
  assumes the checker file is compiled alongside and bound to the design.
*/
`timescale 1ns/1ps
module tb_top;
  import plt_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, clr = 1'b0, hiz = 1'b0;
  logic grp = 1'b0;
  logic [3:0] srcs = 4'h0;
  plt_cfg_t cfg = '0;
  plt_write_t cw = '0, pw = '0;
  logic [15:0] cnt, per, buf0;
  logic ev, roll, dn, tout, toen;
  int n_errors = 0, total_checks = 0;
  plt_timebase i_plt_timebase (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .cfg(cfg),
    .counter_clear_bit(clr), .count_write(cw), .compare_write(pw), .group_load(grp),
    .aux_clock(srcs[1]), .submain_clock(srcs[2]), .external_timer_clock(srcs[0]),
    .alternate_external_clock(srcs[3]), .event_flag_clear(clr), .rollover_flag_clear(clr),
    .output_hiz(hiz), .count_register(cnt), .period_latch(per), .channel0_compare_buffer(buf0),
    .channel_event_flag(ev), .rollover_flag(roll), .count_down(dn), .timer_out(tout),
    .timer_out_en(toen));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  task cyc;
    @(posedge sys_clk);
    #10;
  endtask : cyc
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task pulse(input int s);
    srcs[s] = 1'b1;
    cyc;
    srcs[s] = 1'b0;
    cyc;
  endtask : pulse
  // stop first, then reconfigure, clear and load the period
  task setup(input plt_cfg_t c, input logic [15:0] p);
    plt_cfg_t s;
    s = c;
    s.mode_control = plt_mode_stop;
    cfg.mode_control = plt_mode_stop;
    cyc;
    cfg = s;
    clr = 1'b1;
    pw = '{1'b1, p};
    cyc;
    clr = 1'b0;
    pw = '0;
    cfg = c;
    cyc;
  endtask : setup
  task t_up;
    setup('{plt_mode_up, plt_len_16, plt_src_ext, plt_div_1}, 16'h0002);
    pulse(0);
    chk(cnt, 16'h0001);
    pulse(0);
    chk(cnt, 16'h0002);
    chk({15'h0, ev}, 16'h0001);
    chk({15'h0, tout}, 16'h0001);
    pulse(0);
    chk(cnt, 16'h0000);
    chk({15'h0, roll}, 16'h0001);
    pulse(0);
    chk({15'h0, roll}, 16'h0001);
    cfg.mode_control = plt_mode_stop;
    cw = '{1'b1, 16'h0005};
    cyc;
    cw = '0;
    cfg.mode_control = plt_mode_up;
    cyc;
    cyc;
    chk(cnt, 16'h0000);
    chk({15'h0, toen}, 16'h0001);
    hiz = 1'b1;
    cyc;
    cyc;
    chk({15'h0, toen}, 16'h0000);
    hiz = 1'b0;
    $display("test up done");
  endtask : t_up
  task t_cont;
    setup('{plt_mode_cont, plt_len_8, plt_src_ext, plt_div_1}, 16'h0040);
    cw = '{1'b1, 16'h12fe};
    cyc;
    cw = '0;
    cyc;
    chk(cnt, 16'h00fe);
    chk({15'h0, roll}, 16'h0000);
    pulse(0);
    chk(cnt, 16'h00ff);
    pulse(0);
    chk(cnt, 16'h0000);
    chk({15'h0, roll}, 16'h0001);
    clk_en = 1'b0;
    pulse(0);
    clk_en = 1'b1;
    chk(cnt, 16'h0000);
    cw = '{1'b1, 16'h003f};
    cyc;
    cw = '0;
    pulse(0);
    chk(cnt, 16'h0040);
    chk({15'h0, ev}, 16'h0001);
    $display("test continuous done");
  endtask : t_cont
  task t_updown;
    logic [15:0] seq [4];
    seq = '{16'h0001, 16'h0002, 16'h0001, 16'h0000};
    setup('{plt_mode_updown, plt_len_16, plt_src_ext, plt_div_1}, 16'h0002);
    for (int i = 0; i < 4; i++) begin
      pulse(0);
      chk(cnt, seq[i]);
      chk({15'h0, ev}, {15'h0, i > 0});
      chk({15'h0, roll}, {15'h0, i == 3});
      chk({15'h0, dn}, {15'h0, i > 1});
    end
    $display("test updown done");
  endtask : t_updown
  task t_div;
    setup('{plt_mode_cont, plt_len_16, plt_src_aux, plt_div_4}, 16'h0000);
    pulse(0);
    for (int i = 0; i < 3; i++) pulse(1);
    chk(cnt, 16'h0000);
    pulse(1);
    chk(cnt, 16'h0001);
    cfg.mode_control = plt_mode_stop;
    for (int i = 0; i < 4; i++) pulse(1);
    chk(cnt, 16'h0001);
    clr = 1'b1;
    cyc;
    clr = 1'b0;
    chk(cnt, 16'h0000);
    setup('{plt_mode_cont, plt_len_16, plt_src_submain, plt_div_2}, 16'h0000);
    repeat (2) pulse(2);
    chk(cnt, 16'h0001);
    setup('{plt_mode_cont, plt_len_16, plt_src_alt, plt_div_8}, 16'h0000);
    repeat (7) pulse(3);
    chk(cnt, 16'h0000);
    pulse(3);
    chk(cnt, 16'h0001);
    $display("test divider done");
  endtask : t_div
  task t_period;
    setup('{plt_mode_up, plt_len_16, plt_src_ext, plt_div_1}, 16'h0004);
    repeat (3) pulse(0);
    chk(cnt, 16'h0003);
    pw = '{1'b1, 16'h0001};
    cyc;
    pw = '0;
    pulse(0);
    chk(cnt, 16'h0000);
    chk({15'h0, roll}, 16'h0001);
    pulse(0);
    pw = '{1'b1, 16'h0000};
    cyc;
    pw = '0;
    pulse(0);
    chk(cnt, 16'h0001);
    pw = '{1'b1, 16'h0003};
    cyc;
    pw = '0;
    cyc;
    chk(cnt, 16'h0000);
    pulse(0);
    chk(cnt, 16'h0001);
    grp = 1'b1;
    pw = '{1'b1, 16'h0002};
    cyc;
    grp = 1'b0;
    pw = '0;
    chk(per, 16'h0003);
    chk(buf0, 16'h0002);
    grp = 1'b1;
    cyc;
    grp = 1'b0;
    chk(per, 16'h0002);
    setup('{plt_mode_updown, plt_len_8, plt_src_ext, plt_div_1}, 16'h0100);
    cw = '{1'b1, 16'h00ff};
    cyc;
    cw = '0;
    pulse(0);
    chk(cnt, 16'h0000);
    chk({14'h0, roll, dn}, 16'h0002);
    $display("test period done");
  endtask : t_period
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  initial begin
    repeat (10) @(posedge sys_clk);
    #10 reset_n = 1'b1;
    t_up;
    t_cont;
    t_updown;
    t_period;
    t_div;
    stop_test;
  end
endmodule : tb_top
